// *** logic/hbs_pkg.sv ***
// package: register map, timing constants and carrier types of the holding brake sequencer
package hbs_pkg;

  // ****************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DOUT_SEL = 8'h04;
  localparam logic [7:0] REG_RELEASE_DELAY = 8'h08;
  localparam logic [7:0] REG_HOLD_TIME = 8'h0C;
  localparam logic [7:0] REG_MAG_TIME = 8'h10;
  localparam logic [7:0] REG_MIN_FREQ = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STATUS_BRAKE_BIT = 12;
  localparam int STATUS_STATE_LSB = 16;
  localparam logic [15:0] DOUT_SRC_BRAKE = 16'h145C;
  localparam logic [15:0] DOUT_SEL_RESET = 16'h0000;
  localparam logic [15:0] RELEASE_DELAY_RESET = 16'h0064;
  localparam logic [15:0] HOLD_TIME_RESET = 16'h0064;
  localparam logic [15:0] MAG_TIME_RESET = 16'h0032;
  localparam logic [15:0] MIN_FREQ_RESET = 16'h0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLOCK_HZ = 50_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = CLOCK_HZ / 1_000_000 * TICK_PERIOD_US;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_MAGNETIZE = 3'h1,
    S_RELEASE = 3'h3,
    S_RUN = 3'h2,
    S_RAMP_DOWN = 3'h6,
    S_HOLD = 3'h7
  } hbs_state_type;

  typedef enum logic [1:0] {
    F_OFF = 2'h0,
    F_HOLD_MIN = 2'h1,
    F_SETPOINT = 2'h2,
    F_RAMP_DOWN = 2'h3
  } hbs_freq_type;

  typedef struct packed {
    logic run;
    logic quick_ramp_stop;
    logic coast_stop;
  } hbs_cmd_type;

  typedef struct packed {
    logic pulse_enable;
    hbs_freq_type freq_mode;
  } hbs_drive_type;

  // byte-lane write of a 16-bit register held in the low half of the bus word
  function automatic logic [15:0] hbs_write16(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] sel);
    hbs_write16 = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
  endfunction : hbs_write16

endpackage : hbs_pkg

// *** logic/hbs_ms_timer.sv ***
// module: millisecond phase timer, restarted at the start of each phase
`timescale 1ns/1ps
module hbs_ms_timer #(
  parameter int TICK_CYCLES = 50000,
  parameter int WIDTH = 16
) (
  // clock and control
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // phase
  input wire logic start,
  input wire logic [WIDTH-1:0] limit,
  output logic done
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 1 || WIDTH < 1) begin : g_check
    $error("hbs_ms_timer: TICK_CYCLES and WIDTH must be at least 1");
  end

  logic [PW-1:0] prescale;
  logic [WIDTH-1:0] ms_count;
  wire tick = prescale == PW'(TICK_CYCLES - 1);

  // whole ticks only: a phase lasts exactly limit ticks plus one clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prescale <= '0;
      ms_count <= '0;
    end else if (ce) begin
      if (start) begin // [RQ14]
        prescale <= '0;
        ms_count <= '0;
      end else if (tick) begin
        prescale <= '0;
        if (!done) ms_count <= ms_count + 1'b1; // [RQ14]
      end else begin
        prescale <= prescale + 1'b1;
      end
    end
  end

  assign done = ms_count >= limit;

endmodule : hbs_ms_timer

// *** logic/hbs_top.sv ***
// module: holding brake sequencer with classic Wishbone register slave
// Function
// (RQ1) sequence runs only with enable set
// (RQ2) output selection alone never activates brake
// (RQ3) pulses on, minimum frequency before release
// (RQ4) hold minimum frequency through release delay
// (RQ5) ramp stop: dwell hold time, then apply
// (RQ6) coast stop clears brake bit at once
// (RQ7) brake active is status word bit 12
// (RQ8) output source code selects brake bit
// (RQ9) link master copies bit to relay
// (RQ10) release delay covers opening plus relay
// (RQ11) hold time covers closing plus relay
// (RQ12) magnetizing interval completes before release
// (RQ13) coast stop cancels pulses immediately
// (RQ14) timers count millisecond ticks, restart per phase
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module hbs_top #(
  parameter int TICK_CYCLES = hbs_pkg::TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // commands from pins, ramp generator feedback
  input wire hbs_pkg::hbs_cmd_type CMD,
  input wire logic AT_MIN_FREQ,
  // drive control and brake outputs
  output hbs_pkg::hbs_drive_type DRIVE,
  output logic [15:0] MIN_FREQ,
  output logic [15:0] STATUS_WORD,
  output logic DOUT
);

  if (TICK_CYCLES < 1) begin : g_check
    $error("hbs_top: TICK_CYCLES must be at least 1");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic ctrl_enable;
  logic [15:0] dout_sel;
  logic [15:0] release_delay;
  logic [15:0] hold_time;
  logic [15:0] mag_time;
  hbs_pkg::hbs_state_type state;
  hbs_pkg::hbs_state_type next_state;

  wire bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire bus_wr = bus_req && WB_WE_I;
  wire wr_ctrl = bus_wr && WB_ADR_I == hbs_pkg::REG_CTRL;
  wire wr_dout = bus_wr && WB_ADR_I == hbs_pkg::REG_DOUT_SEL;
  wire wr_rel = bus_wr && WB_ADR_I == hbs_pkg::REG_RELEASE_DELAY;
  wire wr_hold = bus_wr && WB_ADR_I == hbs_pkg::REG_HOLD_TIME;
  wire wr_mag = bus_wr && WB_ADR_I == hbs_pkg::REG_MAG_TIME;
  wire wr_min = bus_wr && WB_ADR_I == hbs_pkg::REG_MIN_FREQ;

  // unmapped addresses read zero and ignore writes, but are still acknowledged
  logic [31:0] rd_mux;
  always_comb begin
    case (WB_ADR_I)
      hbs_pkg::REG_CTRL: rd_mux = {31'h0, ctrl_enable};
      hbs_pkg::REG_DOUT_SEL: rd_mux = {16'h0, dout_sel};
      hbs_pkg::REG_RELEASE_DELAY: rd_mux = {16'h0, release_delay};
      hbs_pkg::REG_HOLD_TIME: rd_mux = {16'h0, hold_time};
      hbs_pkg::REG_MAG_TIME: rd_mux = {16'h0, mag_time};
      hbs_pkg::REG_MIN_FREQ: rd_mux = {16'h0, MIN_FREQ};
      hbs_pkg::REG_STATUS: rd_mux = {13'h0, state, STATUS_WORD};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else if (CE) begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= bus_req ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctrl_enable <= 1'b0;
      dout_sel <= hbs_pkg::DOUT_SEL_RESET;
      release_delay <= hbs_pkg::RELEASE_DELAY_RESET;
      hold_time <= hbs_pkg::HOLD_TIME_RESET;
      mag_time <= hbs_pkg::MAG_TIME_RESET;
      MIN_FREQ <= hbs_pkg::MIN_FREQ_RESET;
    end else if (CE) begin
      if (wr_ctrl && WB_SEL_I[0]) ctrl_enable <= WB_DAT_I[hbs_pkg::CTRL_ENABLE_BIT];
      if (wr_dout) dout_sel <= hbs_pkg::hbs_write16(dout_sel, WB_DAT_I, WB_SEL_I);
      if (wr_rel) release_delay <= hbs_pkg::hbs_write16(release_delay, WB_DAT_I, WB_SEL_I);
      if (wr_hold) hold_time <= hbs_pkg::hbs_write16(hold_time, WB_DAT_I, WB_SEL_I);
      if (wr_mag) mag_time <= hbs_pkg::hbs_write16(mag_time, WB_DAT_I, WB_SEL_I);
      if (wr_min) MIN_FREQ <= hbs_pkg::hbs_write16(MIN_FREQ, WB_DAT_I, WB_SEL_I);
    end
  end

  // ****************************************************************
  // command synchroniser
  // ****************************************************************
  hbs_pkg::hbs_cmd_type cmd_meta;
  hbs_pkg::hbs_cmd_type cmd_sync;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      cmd_meta <= '0;
      cmd_sync <= '0;
    end else if (CE) begin
      cmd_meta <= CMD;
      cmd_sync <= cmd_meta;
    end
  end

  wire stop_req = !cmd_sync.run || cmd_sync.quick_ramp_stop;

  // ****************************************************************
  // phase timer
  // ****************************************************************
  logic phase_done;
  logic [15:0] phase_limit;
  wire phase_start = next_state != state;

  assign phase_limit = state == hbs_pkg::S_MAGNETIZE ? mag_time :
                       state == hbs_pkg::S_RELEASE ? release_delay : hold_time;

  hbs_ms_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .WIDTH(16)
  ) u_timer (
    .clock(CLOCK),
    .rst_n(RST_N),
    .ce(CE),
    .start(phase_start), // [RQ14]
    .limit(phase_limit),
    .done(phase_done)
  );

  // ****************************************************************
  // brake sequence
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      hbs_pkg::S_IDLE: if (!stop_req) next_state = hbs_pkg::S_MAGNETIZE;
      // torque must exist before the brake opens, so magnetizing always runs first
      hbs_pkg::S_MAGNETIZE: begin // [RQ12]
        if (stop_req) next_state = hbs_pkg::S_RAMP_DOWN;
        else if (phase_done) next_state = ctrl_enable ? hbs_pkg::S_RELEASE : hbs_pkg::S_RUN; // [RQ1]
      end
      hbs_pkg::S_RELEASE: begin // [RQ4]
        if (stop_req) next_state = hbs_pkg::S_RAMP_DOWN;
        else if (phase_done) next_state = hbs_pkg::S_RUN;
      end
      hbs_pkg::S_RUN: if (stop_req) next_state = hbs_pkg::S_RAMP_DOWN;
      hbs_pkg::S_RAMP_DOWN: begin // [RQ5]
        if (AT_MIN_FREQ) next_state = ctrl_enable ? hbs_pkg::S_HOLD : hbs_pkg::S_IDLE;
      end
      hbs_pkg::S_HOLD: if (phase_done) next_state = hbs_pkg::S_IDLE; // [RQ5]
      default: next_state = hbs_pkg::S_IDLE;
    endcase
    if (cmd_sync.coast_stop) next_state = hbs_pkg::S_IDLE; // [RQ6] [RQ13]
  end

  // the brake opens only on entry to the release phase, never mid-run when enable is set late,
  // so holding current is always in place before it opens; once open it stays so through hold
  wire brake_opening = next_state == hbs_pkg::S_RELEASE; // [RQ3]
  wire brake_staying = STATUS_WORD[hbs_pkg::STATUS_BRAKE_BIT] &&
                       (next_state == hbs_pkg::S_RUN || next_state == hbs_pkg::S_RAMP_DOWN ||
                        next_state == hbs_pkg::S_HOLD);
  wire next_brake = ctrl_enable && !cmd_sync.coast_stop && (brake_opening || brake_staying); // [RQ1] [RQ6]

  hbs_pkg::hbs_drive_type next_drive;
  always_comb begin
    case (next_state)
      hbs_pkg::S_MAGNETIZE: next_drive = '{1'b1, hbs_pkg::F_HOLD_MIN}; // [RQ3]
      hbs_pkg::S_RELEASE: next_drive = '{1'b1, hbs_pkg::F_HOLD_MIN}; // [RQ3] [RQ4]
      hbs_pkg::S_RUN: next_drive = '{1'b1, hbs_pkg::F_SETPOINT};
      hbs_pkg::S_RAMP_DOWN: next_drive = '{1'b1, hbs_pkg::F_RAMP_DOWN};
      hbs_pkg::S_HOLD: next_drive = '{1'b1, hbs_pkg::F_HOLD_MIN}; // [RQ5]
      default: next_drive = '{1'b0, hbs_pkg::F_OFF}; // [RQ13]
    endcase
  end

  // the output selector alone only routes the bit; enable gates next_brake itself
  wire next_dout = dout_sel == hbs_pkg::DOUT_SRC_BRAKE && next_brake; // [RQ2] [RQ8]

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state <= hbs_pkg::S_IDLE;
      DRIVE <= '{1'b0, hbs_pkg::F_OFF};
      STATUS_WORD <= 16'h0;
      DOUT <= 1'b0;
    end else if (CE) begin
      state <= next_state;
      DRIVE <= next_drive;
      STATUS_WORD <= 16'(next_brake) << hbs_pkg::STATUS_BRAKE_BIT; // [RQ7]
      DOUT <= next_dout;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_brake_needs_enable: assert property (CE && !ctrl_enable |=> !STATUS_WORD[12]) // [RQ1]
    else $error("brake bit set while sequence disabled");

  a_dout_needs_enable: assert property (CE && !ctrl_enable |=> !DOUT) // [RQ2]
    else $error("digital output released brake while sequence disabled");

  a_release_pulses_on: assert property ($rose(STATUS_WORD[12]) |->
    DRIVE.pulse_enable && DRIVE.freq_mode == hbs_pkg::F_HOLD_MIN) // [RQ3]
    else $error("brake released without holding current at minimum frequency");

  a_release_delay_hold: assert property (CE && state == hbs_pkg::S_RELEASE && !phase_done |=>
    DRIVE.freq_mode != hbs_pkg::F_SETPOINT) // [RQ4]
    else $error("setpoint followed before release delay expired");

  a_hold_then_apply: assert property ($fell(STATUS_WORD[12]) && !$past(cmd_sync.coast_stop) &&
    $past(ctrl_enable) |-> $past(state) == hbs_pkg::S_HOLD) // [RQ5]
    else $error("brake applied without holding time after ramp down");

  a_coast_brake: assert property (CE && cmd_sync.coast_stop |=> !STATUS_WORD[12] && !DOUT) // [RQ6]
    else $error("coast stop did not clear brake bit at once");

  a_dout_follows: assert property ($stable(dout_sel) && dout_sel == hbs_pkg::DOUT_SRC_BRAKE |->
    DOUT == STATUS_WORD[12]) // [RQ8]
    else $error("digital output does not follow brake bit");

  a_magnetize_first: assert property ($rose(DRIVE.pulse_enable) |-> state == hbs_pkg::S_MAGNETIZE) // [RQ12]
    else $error("pulses enabled without magnetizing phase");

  a_coast_pulses: assert property (CE && cmd_sync.coast_stop |=>
    !DRIVE.pulse_enable && DRIVE.freq_mode == hbs_pkg::F_OFF) // [RQ13]
    else $error("coast stop did not cancel pulses");

endmodule : hbs_top

// *** tb/hbs_brake_relay.sv ***
// partner: brake relay on the digital output and link master copying the status bit
`timescale 1ns/1ps
module hbs_brake_relay #(
  parameter int SWITCH_CYCLES = 3
) (
  // clock
  input wire logic clock,
  // drive outputs
  input wire logic dout,
  input wire logic [15:0] status_word,
  // brake coil drives
  output logic relay_coil,
  output logic link_coil
);
  logic [SWITCH_CYCLES-1:0] pipe;
  // contact lags the coil by the relay switching time
  always_ff @(posedge clock) begin
    pipe <= {pipe[SWITCH_CYCLES-2:0], dout};
    link_coil <= status_word[12];
  end
  assign relay_coil = pipe[SWITCH_CYCLES-1];
endmodule : hbs_brake_relay

// *** tb/test_hbs_top.sv ***
// testbench: brake sequencer register access and brake sequences
`timescale 1ns/1ps
module test_hbs_top;
  logic clock, rst_n, cyc, stb, we, at_min, dout, relay_coil, link_coil, ack;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel;
  logic [15:0] min_freq, status_word;
  hbs_pkg::hbs_cmd_type cmd;
  hbs_pkg::hbs_drive_type drive;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;

  hbs_top #(.TICK_CYCLES(4)) dut (.CLOCK(clock), .RST_N(rst_n), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CMD(cmd), .AT_MIN_FREQ(at_min), .DRIVE(drive), .MIN_FREQ(min_freq), .STATUS_WORD(status_word),
    .DOUT(dout));
  hbs_brake_relay #(.SWITCH_CYCLES(3)) relay (.clock(clock), .dout(dout), .status_word(status_word),
    .relay_coil(relay_coil), .link_coil(link_coil));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task give_verdict;
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // waits for ack as long as it takes; only the watchdog ends a hung transfer
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // bounded waits on what the drive shows
  task wait_mode(input hbs_pkg::hbs_freq_type m);
    n = 0;
    while (drive.freq_mode !== m && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      $display("wrong value at %0t: drive mode %0d never reached", $time, m);
    end
  endtask : wait_mode

  task wait_brake(input logic v);
    n = 0;
    while (status_word[12] !== v && n < 3000) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_brake

  task reg_defaults;
    logic [7:0] a[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [31:0] e[8] = '{32'h0, 32'h0, 32'h64, 32'h64, 32'h32, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, a[i], 32'h0);
      chk(q, e[i]);
    end
  endtask : reg_defaults

  // release 3 ms covers relay switching plus brake opening, hold 3 ms likewise for closing
  task configure;
    wb(1'b1, 8'h14, 32'h21);
    chk(min_freq, 32'h21);
    wb(1'b1, 8'h14, 32'h0000_FF55, 4'h1);
    chk(min_freq, 32'h55);
    wb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h55);
    wb(1'b1, 8'h10, 32'h2);
    wb(1'b1, 8'h08, 32'h3);
    wb(1'b1, 8'h0C, 32'h3);
    wb(1'b1, 8'h04, 32'h145C);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h3);
  endtask : configure

  task full_sequence;
    cmd.run <= 1'b1;
    wait_mode(hbs_pkg::F_HOLD_MIN);
    chk({drive.pulse_enable, status_word[12]}, 2'b10);
    wait_brake(1'b1);
    chk(n >= 8 && n <= 11, 1);
    chk(drive.freq_mode, hbs_pkg::F_HOLD_MIN);
    wait_mode(hbs_pkg::F_SETPOINT);
    chk(n >= 11 && n <= 15, 1);
    chk({dout, relay_coil, link_coil}, 3'b111);
    wb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0002_1000);
    wb(1'b1, 8'h04, 32'h145B);
    repeat (2) @(posedge clock);
    chk(dout, 1'b0);
    wb(1'b1, 8'h04, 32'h145C);
    cmd.run <= 1'b0;
    wait_mode(hbs_pkg::F_RAMP_DOWN);
    chk(status_word[12], 1'b1);
    at_min <= 1'b1;
    wait_mode(hbs_pkg::F_HOLD_MIN);
    wait_brake(1'b0);
    chk(n >= 11 && n <= 15, 1);
    repeat (4) @(posedge clock);
    chk({drive, dout, relay_coil}, 5'b0);
    at_min <= 1'b0;
  endtask : full_sequence

  task coast_in_run;
    cmd.run <= 1'b1;
    wait_mode(hbs_pkg::F_SETPOINT);
    cmd.coast_stop <= 1'b1;
    wait_mode(hbs_pkg::F_OFF);
    chk(n >= 2 && n <= 4, 1);
    chk({drive, status_word, dout}, 20'h0);
    cmd <= '0;
    repeat (5) @(posedge clock);
  endtask : coast_in_run

  task disabled_run;
    wb(1'b1, 8'h00, 32'h0);
    cmd.run <= 1'b1;
    wait_brake(1'b1);
    chk(n, 3000);
    chk({drive.freq_mode, dout}, {hbs_pkg::F_SETPOINT, 1'b0});
    cmd.run <= 1'b0;
    at_min <= 1'b1;
    wait_mode(hbs_pkg::F_OFF);
    chk(status_word, 16'h0);
  endtask : disabled_run

  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, at_min} = '0;
    adr = '0;
    wdat = '0;
    sel = 4'hF;
    cmd = '0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    reg_defaults();
    configure();
    full_sequence();
    coast_in_run();
    disabled_run();
    give_verdict();
  end

  // hang guard, several times the expected run length
  initial begin
    #(20 * 40000);
    error_cnt++;
    give_verdict();
  end
endmodule : test_hbs_top
